//--- rtl/lxp_cfg.svh
// lxp_cfg.svh: offsets, field positions, reset values and timing counts of the
// loss-of-excitation stage logic. assumes 32-bit ahb-lite word registers.
`ifndef LXP_CFG_SVH
`define LXP_CFG_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define LXP_OFF_CTRL        8'h00
`define LXP_OFF_MIN_CUR     8'h04
`define LXP_OFF_S1_NEAR     8'h08
`define LXP_OFF_S1_FAR      8'h0C
`define LXP_OFF_S1_DELAY    8'h10
`define LXP_OFF_S2_NEAR     8'h14
`define LXP_OFF_S2_FAR      8'h18
`define LXP_OFF_S2_DELAY    8'h1C
`define LXP_OFF_STATE       8'h20
`define LXP_OFF_EVENT       8'h24
`define LXP_OFF_MASK        8'h28

// ----------------------------------------------------------------------------
// control fields
// ----------------------------------------------------------------------------
`define LXP_CTRL_S1_ON      0
`define LXP_CTRL_S1_SO      1
`define LXP_CTRL_S2_ON      2
`define LXP_CTRL_S2_SO      3

// ----------------------------------------------------------------------------
// event / state / mask fields
// ----------------------------------------------------------------------------
`define LXP_EV_S1_START     0
`define LXP_EV_S1_TRIP      1
`define LXP_EV_S2_START     2
`define LXP_EV_S2_TRIP      3

// ----------------------------------------------------------------------------
// reset values (reactance in 0.1 %, delay in ms, current in %)
// ----------------------------------------------------------------------------
`define LXP_CTRL_RST        4'h5
`define LXP_MIN_CUR_RST     8'h14
`define LXP_S1_NEAR_RST     16'h0064
`define LXP_S1_FAR_RST      16'h09A3
`define LXP_S1_DELAY_RST    16'h0BB8
`define LXP_S2_NEAR_RST     16'h0095
`define LXP_S2_FAR_RST      16'h1345
`define LXP_S2_DELAY_RST    16'h0000
`define LXP_MASK_RST        4'h0

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define LXP_TICK_MS         1
`define LXP_CLK_PERIOD_NS   20
`define LXP_CYCLES_PER_MS   ((`LXP_TICK_MS * 1000000) / `LXP_CLK_PERIOD_NS)

`endif

//--- rtl/lxp_pkg.sv
// lxp_pkg: types and shared arithmetic of the loss-of-excitation stage logic.
// assumes impedances are signed in 0.1 % of base, reactance points unsigned.
package lxp_pkg;

	// ------------------------------------------------------------------------
	// bus slave states
	// ------------------------------------------------------------------------
	typedef enum logic [1:0] {
		LXP_BUS_IDLE = 2'b01,
		LXP_BUS_READ = 2'b10
	} lxp_bus_state_t;

	// ------------------------------------------------------------------------
	// offset circle test: circle spans -near..-far on the x axis
	// ------------------------------------------------------------------------
	function automatic logic lxp_in_circle(
		input logic signed [15:0] r,
		input logic signed [15:0] x,
		input logic        [15:0] near,
		input logic        [15:0] far
	);
		logic signed [43:0] dr;
		logic signed [43:0] dx;
		logic signed [43:0] rad;
		dr  = 44'(r) + 44'(r);
		dx  = 44'(x) + 44'(x) + $signed({28'h0, near}) + $signed({28'h0, far});
		rad = $signed({28'h0, far}) - $signed({28'h0, near});
		return (far > near) && ((dr * dr + dx * dx) < (rad * rad));
	endfunction

endpackage

//--- rtl/lxp_stage_logic.sv
// lxp_stage_logic: two-stage loss-of-excitation decision with ahb-lite registers.
// assumes loop impedances and phase currents arrive synchronous to clk.
// Operation
// - impedance counts only while both loop phase currents exceed the minimum percent
// - stage one outputs stay low unless stage one is switched on
// - stage two outputs stay low unless its own switch is on
// - start-only option per stage keeps trip low, start still raised
// - each stage circle is bounded by a near and a far reactance point
// - stage one trip waits its settable millisecond delay
// - stage two has its own delay; zero trips one clock after start
// - separate start output for each stage
// - separate trip output for each stage
// - function block input suppresses all start and trip outputs
// - vt supervision block input suppresses all start and trip outputs
// - a stage operates while an impedance lies inside its offset circle
// - three phase-to-phase loops evaluated continuously; any one qualifies
//
// The AHB-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "lxp_cfg.svh"

module lxp_stage_logic #(
	parameter int CYCLES_PER_MS = `LXP_CYCLES_PER_MS
) (
	input  wire logic               clk,
	input  wire logic               rst,
	input  wire logic               hsel,
	input  wire logic [31:0]        haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic [31:0]        hwdata,
	input  wire logic               hready,
	output logic                    hreadyout,
	output logic                    hresp,
	output logic [31:0]             hrdata,
	input  wire logic signed [15:0] loop12_r_in,
	input  wire logic signed [15:0] loop12_x_in,
	input  wire logic signed [15:0] loop23_r_in,
	input  wire logic signed [15:0] loop23_x_in,
	input  wire logic signed [15:0] loop31_r_in,
	input  wire logic signed [15:0] loop31_x_in,
	input  wire logic [15:0]        phase1_cur_in,
	input  wire logic [15:0]        phase2_cur_in,
	input  wire logic [15:0]        phase3_cur_in,
	input  wire logic               function_block_in,
	input  wire logic               vt_supervision_block_in,
	output logic                    stage_one_start_out,
	output logic                    stage_one_trip_out,
	output logic                    stage_two_start_out,
	output logic                    stage_two_trip_out,
	output logic                    irq
);

	// ------------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------------
	logic [3:0]             ctrl_reg;
	logic [7:0]             min_cur_reg;
	logic [15:0]            s1_near_reg;
	logic [15:0]            s1_far_reg;
	logic [15:0]            s1_delay_reg;
	logic [15:0]            s2_near_reg;
	logic [15:0]            s2_far_reg;
	logic [15:0]            s2_delay_reg;
	logic [3:0]             event_reg;
	logic [3:0]             mask_reg;
	lxp_pkg::lxp_bus_state_t bus_state_reg;
	logic                   wr_pend_reg;
	logic [7:0]             wr_addr_reg;
	logic [7:0]             rd_addr_reg;
	logic                   rd_clear;
	logic [31:0]            rd_value;
	logic                   addr_take;

	// ------------------------------------------------------------------------
	// decision signals
	// ------------------------------------------------------------------------
	logic [15:0]            cur_thr;
	logic [2:0]             loop_cur_ok;
	logic [2:0]             s1_in;
	logic [2:0]             s2_in;
	logic                   blocked;
	logic                   s1_start_next;
	logic                   s2_start_next;
	logic                   s1_expired;
	logic                   s2_expired;
	logic                   s1_trip_next;
	logic                   s2_trip_next;
	logic [3:0]             out_next;
	logic [3:0]             out_now;
	logic [3:0]             event_set;

	// ------------------------------------------------------------------------
	// current condition and offset circles
	// ------------------------------------------------------------------------
	// percent setting against current in 0.1 % units: thr = pct * 10
	assign cur_thr = {5'h00, min_cur_reg, 3'h0} + {7'h00, min_cur_reg, 1'h0};

	always_comb begin
		loop_cur_ok[0] = (phase1_cur_in > cur_thr) && (phase2_cur_in > cur_thr);
		loop_cur_ok[1] = (phase2_cur_in > cur_thr) && (phase3_cur_in > cur_thr);
		loop_cur_ok[2] = (phase3_cur_in > cur_thr) && (phase1_cur_in > cur_thr);
	end

	always_comb begin
		s1_in[0] = lxp_pkg::lxp_in_circle(loop12_r_in, loop12_x_in, s1_near_reg, s1_far_reg);
		s1_in[1] = lxp_pkg::lxp_in_circle(loop23_r_in, loop23_x_in, s1_near_reg, s1_far_reg);
		s1_in[2] = lxp_pkg::lxp_in_circle(loop31_r_in, loop31_x_in, s1_near_reg, s1_far_reg);
		s2_in[0] = lxp_pkg::lxp_in_circle(loop12_r_in, loop12_x_in, s2_near_reg, s2_far_reg);
		s2_in[1] = lxp_pkg::lxp_in_circle(loop23_r_in, loop23_x_in, s2_near_reg, s2_far_reg);
		s2_in[2] = lxp_pkg::lxp_in_circle(loop31_r_in, loop31_x_in, s2_near_reg, s2_far_reg);
	end

	assign blocked = function_block_in || vt_supervision_block_in;

	assign s1_start_next = ctrl_reg[`LXP_CTRL_S1_ON] && !blocked
		&& |(s1_in & loop_cur_ok);
	assign s2_start_next = ctrl_reg[`LXP_CTRL_S2_ON] && !blocked
		&& |(s2_in & loop_cur_ok);

	// ------------------------------------------------------------------------
	// stage delay timers
	// ------------------------------------------------------------------------
	lxp_stage_timer #(
		.CYCLES_PER_MS (CYCLES_PER_MS)
	) u_s1_timer (
		.clk      (clk),
		.rst      (rst),
		.run      (stage_one_start_out),
		.delay_ms (s1_delay_reg),
		.expired  (s1_expired)
	);

	lxp_stage_timer #(
		.CYCLES_PER_MS (CYCLES_PER_MS)
	) u_s2_timer (
		.clk      (clk),
		.rst      (rst),
		.run      (stage_two_start_out),
		.delay_ms (s2_delay_reg),
		.expired  (s2_expired)
	);

	assign s1_trip_next = s1_start_next && s1_expired && !ctrl_reg[`LXP_CTRL_S1_SO];
	assign s2_trip_next = s2_start_next && s2_expired && !ctrl_reg[`LXP_CTRL_S2_SO];

	// ------------------------------------------------------------------------
	// stage outputs
	// ------------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			stage_one_start_out <= 1'b0;
			stage_one_trip_out  <= 1'b0;
			stage_two_start_out <= 1'b0;
			stage_two_trip_out  <= 1'b0;
		end else begin
			stage_one_start_out <= s1_start_next;
			stage_one_trip_out  <= s1_trip_next;
			stage_two_start_out <= s2_start_next;
			stage_two_trip_out  <= s2_trip_next;
		end
	end

	// ------------------------------------------------------------------------
	// sticky events, read-clear; a new rise wins over the clear
	// ------------------------------------------------------------------------
	assign out_next  = {s2_trip_next, s2_start_next, s1_trip_next, s1_start_next};
	assign out_now   = {stage_two_trip_out, stage_two_start_out, stage_one_trip_out, stage_one_start_out};
	assign event_set = out_next & ~out_now;

	always_ff @(posedge clk) begin
		if (rst) begin
			event_reg <= 4'h0;
		end else begin
			event_reg <= (event_reg & ~(rd_clear ? 4'hF : 4'h0)) | event_set;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(((event_reg & ~(rd_clear ? 4'hF : 4'h0)) | event_set) & mask_reg);
		end
	end

	// ------------------------------------------------------------------------
	// ahb-lite slave: writes zero-wait, reads one wait state
	// ------------------------------------------------------------------------
	assign addr_take = hsel && htrans[1] && hready && (bus_state_reg == lxp_pkg::LXP_BUS_IDLE);
	assign rd_clear  = (bus_state_reg == lxp_pkg::LXP_BUS_READ) && (rd_addr_reg == `LXP_OFF_EVENT);

	always_ff @(posedge clk) begin
		if (rst) begin
			bus_state_reg <= lxp_pkg::LXP_BUS_IDLE;
			hreadyout     <= 1'b1;
			hresp         <= 1'b0;
			hrdata        <= 32'h0000_0000;
			wr_pend_reg   <= 1'b0;
			wr_addr_reg   <= 8'h00;
			rd_addr_reg   <= 8'h00;
		end else begin
			hresp       <= 1'b0;
			wr_pend_reg <= addr_take && hwrite;
			if (addr_take) begin
				wr_addr_reg <= haddr[7:0];
				rd_addr_reg <= haddr[7:0];
			end
			unique case (bus_state_reg)
				lxp_pkg::LXP_BUS_IDLE: begin
					if (addr_take && !hwrite) begin
						bus_state_reg <= lxp_pkg::LXP_BUS_READ;
						hreadyout     <= 1'b0;
					end
				end
				lxp_pkg::LXP_BUS_READ: begin
					bus_state_reg <= lxp_pkg::LXP_BUS_IDLE;
					hreadyout     <= 1'b1;
					hrdata        <= rd_value;
				end
			endcase
		end
	end

	always_comb begin
		unique case (rd_addr_reg)
			`LXP_OFF_CTRL:     rd_value = {28'h0, ctrl_reg};
			`LXP_OFF_MIN_CUR:  rd_value = {24'h0, min_cur_reg};
			`LXP_OFF_S1_NEAR:  rd_value = {16'h0, s1_near_reg};
			`LXP_OFF_S1_FAR:   rd_value = {16'h0, s1_far_reg};
			`LXP_OFF_S1_DELAY: rd_value = {16'h0, s1_delay_reg};
			`LXP_OFF_S2_NEAR:  rd_value = {16'h0, s2_near_reg};
			`LXP_OFF_S2_FAR:   rd_value = {16'h0, s2_far_reg};
			`LXP_OFF_S2_DELAY: rd_value = {16'h0, s2_delay_reg};
			`LXP_OFF_STATE:    rd_value = {28'h0, out_now};
			`LXP_OFF_EVENT:    rd_value = {28'h0, event_reg};
			`LXP_OFF_MASK:     rd_value = {28'h0, mask_reg};
			default:           rd_value = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_reg     <= `LXP_CTRL_RST;
			min_cur_reg  <= `LXP_MIN_CUR_RST;
			s1_near_reg  <= `LXP_S1_NEAR_RST;
			s1_far_reg   <= `LXP_S1_FAR_RST;
			s1_delay_reg <= `LXP_S1_DELAY_RST;
			s2_near_reg  <= `LXP_S2_NEAR_RST;
			s2_far_reg   <= `LXP_S2_FAR_RST;
			s2_delay_reg <= `LXP_S2_DELAY_RST;
			mask_reg     <= `LXP_MASK_RST;
		end else if (wr_pend_reg) begin
			unique case (wr_addr_reg)
				`LXP_OFF_CTRL:     ctrl_reg     <= hwdata[3:0];
				`LXP_OFF_MIN_CUR:  min_cur_reg  <= hwdata[7:0];
				`LXP_OFF_S1_NEAR:  s1_near_reg  <= hwdata[15:0];
				`LXP_OFF_S1_FAR:   s1_far_reg   <= hwdata[15:0];
				`LXP_OFF_S1_DELAY: s1_delay_reg <= hwdata[15:0];
				`LXP_OFF_S2_NEAR:  s2_near_reg  <= hwdata[15:0];
				`LXP_OFF_S2_FAR:   s2_far_reg   <= hwdata[15:0];
				`LXP_OFF_S2_DELAY: s2_delay_reg <= hwdata[15:0];
				`LXP_OFF_MASK:     mask_reg     <= hwdata[3:0];
				default:           ;
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------------
	min_current_gate_a: assert property (@(posedge clk) disable iff (rst)
		(loop_cur_ok == 3'b000) |=> !stage_one_start_out && !stage_two_start_out)
		else $error("start raised without sufficient phase current");

	stage_one_off_a: assert property (@(posedge clk) disable iff (rst)
		!ctrl_reg[`LXP_CTRL_S1_ON] |=> !stage_one_start_out && !stage_one_trip_out)
		else $error("stage one active while switched off");

	stage_two_off_a: assert property (@(posedge clk) disable iff (rst)
		!ctrl_reg[`LXP_CTRL_S2_ON] |=> !stage_two_start_out && !stage_two_trip_out)
		else $error("stage two active while switched off");

	start_only_a: assert property (@(posedge clk) disable iff (rst)
		ctrl_reg[`LXP_CTRL_S1_SO] && ctrl_reg[`LXP_CTRL_S2_SO] |=> !stage_one_trip_out && !stage_two_trip_out)
		else $error("trip raised in start-only mode");

	zero_delay_trip_a: assert property (@(posedge clk) disable iff (rst)
		stage_two_start_out && s2_start_next && (s2_delay_reg == 16'h0000) && !ctrl_reg[`LXP_CTRL_S2_SO]
		|=> stage_two_trip_out)
		else $error("undelayed stage two trip missing");

	trip_with_start_a: assert property (@(posedge clk) disable iff (rst)
		(stage_one_trip_out |-> stage_one_start_out) and (stage_two_trip_out |-> stage_two_start_out))
		else $error("trip present without start");

	general_block_a: assert property (@(posedge clk) disable iff (rst)
		function_block_in |=> (out_now == 4'h0))
		else $error("output asserted while function blocked");

	vt_block_a: assert property (@(posedge clk) disable iff (rst)
		vt_supervision_block_in |=> (out_now == 4'h0))
		else $error("output asserted while vt supervision blocks");

	circle_start_a: assert property (@(posedge clk) disable iff (rst)
		ctrl_reg[`LXP_CTRL_S1_ON] && !blocked && ((s1_in & loop_cur_ok) != 3'b000) |=> stage_one_start_out)
		else $error("stage one start missing for impedance inside circle");

	delay_early_a: assert property (@(posedge clk) disable iff (rst)
		$rose(stage_one_start_out) && (s1_delay_reg != 16'h0000) |-> !stage_one_trip_out ##1 !stage_one_trip_out)
		else $error("stage one tripped before its delay");

endmodule // lxp_stage_logic

//--- rtl/lxp_stage_timer.sv
// lxp_stage_timer: millisecond delay of one stage, restarted whenever run drops.
// assumes run is a registered level of the stage start condition.
`timescale 1ns/1ps
`include "lxp_cfg.svh"

module lxp_stage_timer #(
	parameter int CYCLES_PER_MS = `LXP_CYCLES_PER_MS
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        run,
	input  wire logic [15:0] delay_ms,
	output logic             expired
);
	localparam int PW = $clog2(CYCLES_PER_MS + 1);

	logic [PW-1:0] pre_reg;
	logic [15:0]   ms_reg;

	// ------------------------------------------------------------------------
	// prescaler and ms count, both cleared while idle
	// ------------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst || !run) begin
			pre_reg <= '0;
			ms_reg  <= '0;
		end else if (ms_reg != 16'hFFFF) begin
			if (pre_reg == PW'(CYCLES_PER_MS - 1)) begin
				pre_reg <= '0;
				ms_reg  <= ms_reg + 16'h0001;
			end else begin
				pre_reg <= pre_reg + PW'(1);
			end
		end
	end

	assign expired = run && (ms_reg >= delay_ms);

	timer_restart_a: assert property (@(posedge clk) disable iff (rst)
		!run |=> (ms_reg == 16'h0000) && (pre_reg == '0))
		else $error("stage timer not restarted after run dropped");

endmodule // lxp_stage_timer

//--- verif/lxp_far_logic.sv
// lxp_far_logic: model of the user binary logic and output relays beyond the stages.
// assumes stage outputs are registered levels in the clk domain.
`timescale 1ns/1ps

module lxp_far_logic (
	input  wire logic stage_one_start_out,
	input  wire logic stage_one_trip_out,
	input  wire logic stage_two_start_out,
	input  wire logic stage_two_trip_out,
	input  wire logic vt_breaker_tripped_in,
	output logic      vt_supervision_block_in,
	output logic      common_start_out,
	output logic      common_trip_out
);
	assign common_start_out = stage_one_start_out | stage_two_start_out;
	assign common_trip_out  = stage_one_trip_out | stage_two_trip_out;
	// a tripped vt breaker leaves no valid voltage, so the function must be held off
	assign vt_supervision_block_in = vt_breaker_tripped_in;
endmodule // lxp_far_logic

//--- verif/tb_loss_of_excitation_stage_logic.sv
// tb_loss_of_excitation_stage_logic: self-checking bench of the stage logic.
// assumes the design is the only ahb-lite slave, hready tied to hreadyout.
`timescale 1ns/1ps
`include "lxp_cfg.svh"

module tb_loss_of_excitation_stage_logic;
	typedef struct {
		string       what;
		bit          rd;
		logic [31:0] exp;
	} lxp_note_t;

	logic               clk, rst, hsel, hwrite, hreadyout, hresp, irq;
	logic        [31:0] haddr, hwdata, hrdata, rd_got;
	logic        [1:0]  htrans;
	logic signed [15:0] r12, x12, r23, x23, r31, x31;
	logic        [15:0] cur;
	logic               fblk, vt_trip, vt_blk, s1s, s1t, s2s, s2t, cst, ctr;
	lxp_note_t          q[$];
	lxp_note_t          note;
	int                 miscompares = 0;
	int                 n_checks = 0;
	event               seen;
	logic        [7:0]  r_off [12] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20,
	                                   8'h24, 8'h28, 8'h2C};
	logic        [31:0] r_rst [12] = '{32'h5, 32'h14, 32'h64, 32'h9A3, 32'hBB8, 32'h95, 32'h1345, 32'h0,
	                                   32'h0, 32'h0, 32'h0, 32'h0};
	logic        [3:0]  c_cfg [4] = '{4'h4, 4'h1, 4'hF, 4'h5};
	logic        [4:0]  c_exp [4] = '{5'h0C, 5'h03, 5'h05, 5'h0F};

	lxp_stage_logic #(.CYCLES_PER_MS(10)) uut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .loop12_r_in(r12), .loop12_x_in(x12),
		.loop23_r_in(r23), .loop23_x_in(x23), .loop31_r_in(r31), .loop31_x_in(x31),
		.phase1_cur_in(cur), .phase2_cur_in(cur), .phase3_cur_in(cur), .function_block_in(fblk),
		.vt_supervision_block_in(vt_blk), .stage_one_start_out(s1s), .stage_one_trip_out(s1t),
		.stage_two_start_out(s2s), .stage_two_trip_out(s2t), .irq(irq));

	lxp_far_logic far_side (.stage_one_start_out(s1s), .stage_one_trip_out(s1t),
		.stage_two_start_out(s2s), .stage_two_trip_out(s2t), .vt_breaker_tripped_in(vt_trip),
		.vt_supervision_block_in(vt_blk), .common_start_out(cst), .common_trip_out(ctr));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task automatic give_verdict;
		$display("checks %0d, miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// single transfer: address phase held until hready, then data phase until hready
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= wr;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		rd_got = hrdata;
	endtask

	task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
		q.push_back('{what, 1'b1, exp});
		bus(1'b0, a, 32'h0);
		->seen;
	endtask

	task automatic out_chk(input int n, input logic [4:0] exp);
		repeat (n) @(posedge clk);
		#1;
		q.push_back('{"outputs", 1'b0, {27'h0, exp}});
		->seen;
	endtask

	// drive loop reactances with a small random resistance and one current for all phases
	task automatic zin(input int a, input int b, input int c, input int i);
		@(posedge clk);
		x12 <= 16'(a);
		x23 <= 16'(b);
		x31 <= 16'(c);
		r12 <= 16'(int'($urandom_range(20)) - 10);
		r23 <= 16'(int'($urandom_range(20)) - 10);
		r31 <= 16'(int'($urandom_range(20)) - 10);
		cur <= 16'(i);
	endtask

	always @(seen) begin
		note = q.pop_front();
		if (note.rd) begin
			check(note.what, rd_got, note.exp);
			check("bus response", {31'h0, hresp}, 32'h0);
		end else begin
			check(note.what, {27'h0, irq, s2t, s2s, s1t, s1s}, note.exp);
			check("common", {30'h0, cst, ctr}, {30'h0, note.exp[0] | note.exp[2], note.exp[1] | note.exp[3]});
		end
	end

	initial begin
		#200000;
		miscompares++;
		give_verdict();
	end

	initial begin
		{rst, hsel, hwrite, fblk, vt_trip} = 5'b10000;
		{haddr, hwdata, htrans} = '0;
		{r12, x12, r23, x23, r31, x31, cur} = '0;
		void'($urandom(22));
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		for (int k = 0; k < 12; k++) rd_chk("reset value", r_off[k], r_rst[k]);
		bus(1'b1, 8'h2C, 32'hFFFFFFFF);
		rd_chk("unmapped", 8'h2C, 32'h0);
		bus(1'b1, `LXP_OFF_S1_DELAY, 32'h3);
		rd_chk("stage one delay", `LXP_OFF_S1_DELAY, 32'h3);
		$display("test registers done");
		zin(-3000, 500, 500, 201);
		out_chk(2, 5'h0C);
		zin(-3000, 500, 500, 200);
		out_chk(2, 5'h00);
		zin(500, 500, -1000, 201);
		out_chk(2, 5'h0D);
		out_chk(29, 5'h0D);
		out_chk(3, 5'h0F);
		$display("test delays done");
		zin(-1000, 500, 500, 201);
		out_chk(20, 5'h0F);
		zin(500, 500, 500, 201);
		out_chk(2, 5'h00);
		zin(-1000, 500, 500, 201);
		out_chk(29, 5'h0D);
		out_chk(3, 5'h0F);
		@(posedge clk);
		fblk <= 1'b1;
		out_chk(2, 5'h00);
		@(posedge clk);
		fblk <= 1'b0;
		out_chk(2, 5'h0D);
		@(posedge clk);
		vt_trip <= 1'b1;
		out_chk(2, 5'h00);
		@(posedge clk);
		vt_trip <= 1'b0;
		$display("test blocking done");
		for (int k = 0; k < 4; k++) begin
			bus(1'b1, `LXP_OFF_CTRL, {28'h0, c_cfg[k]});
			zin(500, 500, 500, 201);
			zin(-1000, -1000, 500, 300);
			out_chk(34, c_exp[k]);
		end
		$display("test enables done");
		zin(500, 500, 500, 201);
		out_chk(2, 5'h00);
		bus(1'b1, `LXP_OFF_MASK, 32'h1);
		out_chk(2, 5'h10);
		bus(1'b1, `LXP_OFF_MASK, 32'h0);
		out_chk(2, 5'h00);
		bus(1'b1, `LXP_OFF_MASK, 32'hF);
		rd_chk("event", `LXP_OFF_EVENT, 32'hF);
		out_chk(2, 5'h00);
		rd_chk("event cleared", `LXP_OFF_EVENT, 32'h0);
		$display("test interrupt done");
		bus(1'b1, `LXP_OFF_MIN_CUR, 32'h1E);
		zin(-1000, 500, 500, 300);
		out_chk(2, 5'h00);
		zin(-1000, 500, 500, 301);
		out_chk(2, 5'h1D);
		$display("test threshold done");
		give_verdict();
	end
endmodule // tb_loss_of_excitation_stage_logic
